/* File: verilog/dib_seq.sv */
// dc injection brake sequencer top
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - braking settings act only in volts-per-hertz mode, ignored in vector modes
// - brake level 0-20.00 percent, full scale is 1.414 x max volts x 20%
// - trigger frequency 0-50 Hz sets where braking engages while decelerating
// - brake-on-stop arms on stop; dc applied once frequency reaches trigger
// - stop braking ends automatically after stop brake time, up to 60 s
// - braking begun below trigger scales time by frequency over trigger
// - brake-on-reverse makes a direction change start braking at once, at any frequency
// - reverse braking lasts until motor stopped or stop brake time exhausted
// - after reverse braking the motor accelerates in the new direction
// - brake-on-start brakes for start brake time before running
// - start braking ends automatically, then acceleration begins
// - no start brake interval unless brake-on-start is set
// - overload fault after one time constant at twice rated watts
// - overload fault after half a time constant at three times rated watts
// - reverse rotation setting inverts commanded direction
`timescale 1ns/1ps
`include "dib_params.svh"
module dib_seq #(
    parameter int TICK_CYCLES = `DIB_TICK_CYCLES
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // configuration
    input wire logic [1:0] ctrl_mode,
    input wire logic [15:0] brake_level,
    input wire logic [15:0] brake_trigger,
    input wire logic brake_on_stop,
    input wire logic brake_on_reverse,
    input wire logic brake_on_start,
    input wire logic [15:0] stop_brake_time,
    input wire logic [15:0] start_brake_time,
    input wire logic [15:0] thermal_tau,
    input wire logic reverse_rotation,
    // commands and drive state, same clock
    input wire logic run_cmd,
    input wire logic dir_cmd,
    input wire logic [15:0] out_freq,
    input wire logic motor_stopped,
    input wire logic [15:0] max_out_volts,
    // resistor power as multiple of rating, in quarters
    input wire logic [3:0] regen_load,
    // outputs to the inverter stage
    output logic dc_brake_on,
    output logic [15:0] dc_brake_volts,
    output logic accel_enable,
    output logic decel_request,
    output logic out_dir,
    output logic regen_fault
);
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ****************************************
    // tick
    // ****************************************
    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES too small");
    end
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= '0;
        else if (tick_cnt == 32'(TICK_CYCLES - 1))
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // ****************************************
    // settings
    // ****************************************
    logic vf, en_stop, en_rev, en_start;
    logic [15:0] trig, lvl, stop_t;
    assign vf = (ctrl_mode == `DIB_MODE_VF);
    assign en_stop = vf && brake_on_stop;
    assign en_rev = vf && brake_on_reverse;
    assign en_start = vf && brake_on_start;
    assign trig = (brake_trigger > `DIB_TRIG_MAX) ? `DIB_TRIG_MAX : brake_trigger;
    assign lvl = (brake_level > `DIB_LEVEL_MAX) ? `DIB_LEVEL_MAX : brake_level;
    assign stop_t = (stop_brake_time > `DIB_BTIME_MAX) ? `DIB_BTIME_MAX : stop_brake_time;

    // volts = max * 0.2828 * lvl / 2000
    logic [31:0] full_v;
    logic [47:0] lvl_v;
    assign full_v = max_out_volts * `DIB_LEVEL_SCALE;
    assign lvl_v = (48'(full_v[31:16]) * 48'(lvl)) / 48'(`DIB_LEVEL_MAX);

    // brake time scaled when braking begins below trigger
    logic [31:0] scaled_t;
    logic [15:0] stop_load;
    assign scaled_t = (trig == 16'h0000) ? 32'(stop_t) : (32'(stop_t) * 32'(out_freq)) / 32'(trig);
    assign stop_load = (out_freq < trig) ? scaled_t[15:0] : stop_t;

    // ****************************************
    // sequencer
    // ****************************************
    dib_pkg::dib_state_t state;
    logic run_d, dir_d, tmr_load, tmr_done, start_load, chk_on;
    logic [15:0] tmr_val, start_t;
    assign start_t = (start_brake_time > `DIB_BTIME_MAX) ? `DIB_BTIME_MAX : start_brake_time;
    assign start_load = run_cmd && !run_d && en_start;

    always_comb
    begin
        tmr_load = 1'b0;
        tmr_val = stop_load;
        case (state)
            dib_pkg::DIB_IDLE:
            begin
                tmr_load = start_load;
                tmr_val = start_t;
            end
            dib_pkg::DIB_RUN:
                tmr_load = en_rev && (dir_cmd != dir_d);
            dib_pkg::DIB_STOP_WAIT:
                tmr_load = out_freq <= trig;
            default:
                tmr_load = 1'b0;
        endcase
    end

    dib_timer #(.WIDTH(16)) u_brk_tmr (
        .clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_d <= 1'b0;
            dir_d <= 1'b0;
            chk_on <= 1'b0;
        end
        else
        begin
            // flops first move one edge after reset lifts, so checks start then
            chk_on <= 1'b1;
            run_d <= run_cmd;
            if (state != dib_pkg::DIB_REV_BRK)
                dir_d <= dir_cmd;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= dib_pkg::DIB_IDLE;
        else
            case (state)
                dib_pkg::DIB_IDLE:
                    if (run_cmd)
                        state <= en_start ? dib_pkg::DIB_START_BRK : dib_pkg::DIB_RUN;
                dib_pkg::DIB_START_BRK:
                    if (tmr_done)
                        state <= dib_pkg::DIB_RUN;
                dib_pkg::DIB_RUN:
                    if (!run_cmd)
                        state <= en_stop ? dib_pkg::DIB_STOP_WAIT : dib_pkg::DIB_IDLE;
                    else if (en_rev && dir_cmd != dir_d)
                        state <= dib_pkg::DIB_REV_BRK;
                dib_pkg::DIB_STOP_WAIT:
                    if (out_freq <= trig)
                        state <= dib_pkg::DIB_STOP_BRK;
                dib_pkg::DIB_STOP_BRK:
                    if (tmr_done)
                        state <= dib_pkg::DIB_IDLE;
                dib_pkg::DIB_REV_BRK:
                    if (tmr_done || motor_stopped)
                        state <= dib_pkg::DIB_RUN;
                default:
                    state <= dib_pkg::DIB_IDLE;
            endcase
    end

    // ****************************************
    // outputs
    // ****************************************
    logic brk;
    assign brk = (state == dib_pkg::DIB_START_BRK) || (state == dib_pkg::DIB_STOP_BRK) ||
                 (state == dib_pkg::DIB_REV_BRK);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dc_brake_on <= 1'b0;
            dc_brake_volts <= 16'h0000;
            accel_enable <= 1'b0;
            decel_request <= 1'b0;
            out_dir <= 1'b0;
        end
        else
        begin
            dc_brake_on <= brk;
            dc_brake_volts <= brk ? lvl_v[15:0] : 16'h0000;
            accel_enable <= (state == dib_pkg::DIB_RUN) && run_cmd;
            decel_request <= (state == dib_pkg::DIB_STOP_WAIT);
            out_dir <= dir_d ^ reverse_rotation;
        end
    end

    // ****************************************
    // resistor thermal model
    // ****************************************
    // heat rises by the excess over rating, in quarters, per tick and decays by one at or below it
    // limit 40 * tau: 2x adds 4 a tick and trips after tau, 3x adds 8 and trips after tau/2
    logic [39:0] heat, heat_lim;
    logic [15:0] tau;
    logic [3:0] excess;
    assign tau = (thermal_tau > `DIB_TAU_MAX) ? `DIB_TAU_MAX : thermal_tau;
    assign excess = regen_load - 4'h4;
    assign heat_lim = 40'(tau) * 40'h28;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            heat <= '0;
            regen_fault <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                if (regen_load > 4'h4)
                    heat <= heat + 40'(excess);
                else if (heat != '0)
                    heat <= heat - 40'h1;
            end
            if (heat >= heat_lim && heat_lim != '0)
                regen_fault <= 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_vector_no_brake: assert property (@(posedge sys_clk) disable iff (!chk_on)
        (ctrl_mode != `DIB_MODE_VF) && state == dib_pkg::DIB_IDLE && run_cmd |=> state == dib_pkg::DIB_RUN)
        else $error("vector mode entered start braking");
    a_start_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_IDLE && run_cmd && !en_start |=> state != dib_pkg::DIB_START_BRK)
        else $error("start brake without option");
    a_stop_engage: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_STOP_WAIT && out_freq <= trig |=> ##1 dc_brake_on)
        else $error("stop brake not applied at trigger");
    a_rev_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_RUN && run_cmd && en_rev && dir_cmd != dir_d |=> state == dib_pkg::DIB_REV_BRK)
        else $error("reverse brake not started");
    a_rev_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_REV_BRK && motor_stopped |=> state == dib_pkg::DIB_RUN)
        else $error("reverse brake outlived stop");
    a_start_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_START_BRK && tmr_done |=> state == dib_pkg::DIB_RUN)
        else $error("start brake not released");
    a_stop_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == dib_pkg::DIB_STOP_BRK && tmr_done |=> ##1 !dc_brake_on)
        else $error("stop brake not released");
    a_dir_invert: assert property (@(posedge sys_clk) disable iff (!chk_on)
        $stable(dir_d) && $stable(reverse_rotation) |=> out_dir == ($past(dir_d) ^ $past(reverse_rotation)))
        else $error("direction not inverted");
    a_volts_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !dc_brake_on |-> dc_brake_volts == 16'h0000)
        else $error("brake volts without braking");
    a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regen_fault |=> regen_fault)
        else $error("fault dropped");
    c_stop_brake: cover property (@(posedge sys_clk) disable iff (!rst_n) state == dib_pkg::DIB_STOP_BRK);
    c_rev_brake: cover property (@(posedge sys_clk) disable iff (!rst_n) state == dib_pkg::DIB_REV_BRK);
    c_start_brake: cover property (@(posedge sys_clk) disable iff (!rst_n) state == dib_pkg::DIB_START_BRK);
    c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n) regen_fault);
endmodule

/* File: verilog/dib_params.svh */
// constants for the dc injection brake sequencer
`ifndef DIB_PARAMS_SVH
`define DIB_PARAMS_SVH
// tick of 0.1 s at 100 MHz
`define DIB_TICK_NS 100000000
`define DIB_CLK_NS 10
`define DIB_TICK_CYCLES (`DIB_TICK_NS / `DIB_CLK_NS)
// settings in hundredths (percent, hertz), times in tenths of a second
`define DIB_LEVEL_MAX 16'h07D0
`define DIB_TRIG_MAX 16'h1388
`define DIB_BTIME_MAX 16'h0258
`define DIB_TAU_MAX 16'h0E10
// 1.414 * 20% as a 16-bit fraction scale: 0.2828 * 65536
`define DIB_LEVEL_SCALE 16'h4866
`define DIB_MODE_VF 2'h0
`endif

/* File: verilog/dib_pkg.sv */
// types for the dc injection brake sequencer
package dib_pkg;
    typedef enum logic [2:0] {DIB_IDLE, DIB_START_BRK, DIB_RUN, DIB_STOP_WAIT, DIB_STOP_BRK, DIB_REV_BRK} dib_state_t;
endpackage

/* File: verilog/dib_timer.sv */
// down counter of 0.1 s ticks used for brake intervals
`timescale 1ns/1ps
module dib_timer #(
    parameter int WIDTH = 16
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic tick,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    // status
    output logic done
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("WIDTH too small");
    end
    logic [WIDTH-1:0] cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= '0;
        else if (load)
            cnt <= load_val;
        else if (tick && cnt != '0)
            cnt <= cnt - 1'b1;
    end
    assign done = (cnt == '0) && !load;
endmodule

/* File: bench/dib_motor_model.sv */
// inverter stage and motor model for the brake sequencer bench
`timescale 1ns/1ps
module dib_motor_model (
    // clock
    input wire logic sys_clk,
    // drive outputs
    input wire logic accel_enable,
    input wire logic dc_brake_on,
    input wire logic [7:0] step,
    // motor state
    output logic [15:0] out_freq,
    output logic motor_stopped
);
    initial out_freq = 16'h0000;
    // no reset: a spinning motor does not stop because the logic was reset
    always @(posedge sys_clk)
    begin
        if (accel_enable && !dc_brake_on)
            out_freq <= (out_freq + step > 16'h09C4) ? 16'h09C4 : out_freq + step;
        else
            out_freq <= (out_freq > step) ? out_freq - step : 16'h0000;
    end
    assign motor_stopped = (out_freq == 16'h0000);
endmodule

/* File: bench/dib_seq_tb.sv */
// self-checking bench for the dc injection brake sequencer
`timescale 1ns/1ps
module dib_seq_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] ctrl_mode;
    logic [15:0] brake_level, brake_trigger, stop_brake_time, start_brake_time, thermal_tau, max_out_volts;
    logic brake_on_stop, brake_on_reverse, brake_on_start, reverse_rotation, run_cmd, dir_cmd;
    logic [3:0] regen_load;
    logic [7:0] step;
    logic [15:0] out_freq, dc_brake_volts, v, f;
    logic motor_stopped, dc_brake_on, accel_enable, decel_request, out_dir, regen_fault, d, seen;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    longint e;
    // ****************************************
    // design and partner
    // ****************************************
    dib_seq #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .ctrl_mode(ctrl_mode),
        .brake_level(brake_level), .brake_trigger(brake_trigger), .brake_on_stop(brake_on_stop),
        .brake_on_reverse(brake_on_reverse), .brake_on_start(brake_on_start),
        .stop_brake_time(stop_brake_time), .start_brake_time(start_brake_time), .thermal_tau(thermal_tau),
        .reverse_rotation(reverse_rotation), .run_cmd(run_cmd), .dir_cmd(dir_cmd), .out_freq(out_freq),
        .motor_stopped(motor_stopped), .max_out_volts(max_out_volts), .regen_load(regen_load),
        .dc_brake_on(dc_brake_on), .dc_brake_volts(dc_brake_volts), .accel_enable(accel_enable),
        .decel_request(decel_request), .out_dir(out_dir), .regen_fault(regen_fault));
    dib_motor_model u_motor (.sys_clk(sys_clk), .accel_enable(accel_enable), .dc_brake_on(dc_brake_on),
        .step(step), .out_freq(out_freq), .motor_stopped(motor_stopped));
    always #5 sys_clk = ~sys_clk;
    // ****************************************
    // helpers
    // ****************************************
    task automatic summarize();
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic rst_seq();
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    // waits for braking, notes volts and frequency at its start, counts cycles held
    task automatic brake_len();
        int w;
        w = 0;
        n = 0;
        while (dc_brake_on !== 1'b1 && w < 300)
        begin
            @(negedge sys_clk);
            w++;
        end
        v = dc_brake_volts;
        f = out_freq;
        while (dc_brake_on === 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // ten thousand cycles is several times the whole sequence
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            miscompares++;
            summarize();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        {ctrl_mode, brake_on_stop, brake_on_reverse, brake_on_start, reverse_rotation, run_cmd, dir_cmd} = '0;
        {brake_level, brake_trigger, stop_brake_time, start_brake_time, thermal_tau, max_out_volts} = '0;
        regen_load = 4'h0;
        step = 8'h32;
        void'($urandom(32'h7A61));
        rst_seq();
        chk("idle", {dc_brake_on, accel_enable, decel_request, out_dir, regen_fault, |dc_brake_volts}, 0);
        brake_on_start = 1'b1;
        start_brake_time = 16'h0003;
        run_cmd = 1'b1;
        brake_len();
        chk("start_len", n >= 8 && n <= 17, 1);
        repeat (3) @(negedge sys_clk);
        chk("start_accel", accel_enable, 1);
        // option off in v/f mode, then option on in each vector mode
        for (int k = 0; k < 4; k++)
        begin
            run_cmd = 1'b0;
            ctrl_mode = k[1:0];
            brake_on_start = (k != 0);
            rst_seq();
            run_cmd = 1'b1;
            seen = 1'b0;
            repeat (20) @(negedge sys_clk) seen |= dc_brake_on;
            chk("no_start_brake", {seen, accel_enable}, 2'h1);
        end
        ctrl_mode = 2'h0;
        brake_on_start = 1'b0;
        brake_on_stop = 1'b1;
        brake_trigger = 16'h03E8;
        stop_brake_time = 16'h0003;
        // random level, then an out-of-range level that must clamp to full
        for (int i = 0; i < 2; i++)
        begin
            max_out_volts = 16'($urandom_range(1, 16'hFFFF));
            brake_level = i ? 16'hFFFF : 16'($urandom_range(0, 16'h07D0));
            run_cmd = 1'b1;
            repeat (60) @(negedge sys_clk);
            run_cmd = 1'b0;
            repeat (3) @(negedge sys_clk);
            chk("decel_req", decel_request, 1);
            brake_len();
            chk("stop_len", n >= 8 && n <= 17, 1);
            chk("brake_freq", f <= brake_trigger, 1);
            e = (longint'(max_out_volts) * 18534 * (i ? 2000 : brake_level)) / 131072000;
            chk("brake_volts", v + 2 >= e && v <= e + 2, 1);
            chk("volts_off", dc_brake_volts, 0);
        end
        // braking begun well under the trigger runs for about half the time
        stop_brake_time = 16'h0014;
        brake_trigger = 16'h1388;
        run_cmd = 1'b1;
        repeat (60) @(negedge sys_clk);
        step = 8'h01;
        run_cmd = 1'b0;
        brake_len();
        chk("scaled_len", n >= 28 && n <= 48, 1);
        brake_on_stop = 1'b0;
        brake_on_reverse = 1'b1;
        brake_trigger = 16'h03E8;
        // row 0 ends at standstill, row 1 ends on the stop brake time
        for (int j = 0; j < 2; j++)
        begin
            reverse_rotation = 1'($urandom);
            stop_brake_time = j ? 16'h0003 : 16'h00C8;
            step = 8'h32;
            run_cmd = 1'b1;
            repeat (60) @(negedge sys_clk);
            step = j ? 8'h01 : 8'h32;
            d = dir_cmd;
            dir_cmd = ~d;
            brake_len();
            chk("rev_brake", n > 0, 1);
            chk("rev_len", j ? (n >= 8 && n <= 17) : (n <= 70), 1);
            repeat (4) @(negedge sys_clk);
            chk("rev_accel", accel_enable, 1);
            chk("rev_dir", out_dir, 1'(~d ^ reverse_rotation));
        end
        run_cmd = 1'b0;
        thermal_tau = 16'h0001;
        // resistor at 1x, 2x and 3x rating
        for (int t = 1; t < 4; t++)
        begin
            regen_load = 4'h0;
            rst_seq();
            regen_load = 4'(4 * t);
            n = 0;
            while (regen_fault !== 1'b1 && n < 200)
            begin
                @(negedge sys_clk);
                n++;
            end
            chk("fault_time", t == 1 ? n == 200 : t == 2 ? n >= 38 && n <= 42 : n >= 18 && n <= 22, 1);
        end
        summarize();
    end
endmodule
